// file: src/adc_cmd_pkg.sv
// constants shared by the command interpreter and its serial port
package adc_cmd_pkg;
  // serial framing and baud measurement
  localparam int           CNT_W        = 20;
  localparam logic [7:0]   SYNC_BYTE    = 8'h55;
  localparam logic [2:0]   SYNC_EDGES   = 3'h4;
  localparam int           SYNC_SHIFT   = 3;
  localparam logic [3:0]   DATA_BITS    = 4'h8;
  // command encodings, compared against byte[7:1] or byte[7:4]
  localparam logic [6:0]   CMD_RESET    = 7'h03;
  localparam logic [6:0]   CMD_START    = 7'h04;
  localparam logic [6:0]   CMD_SLEEP    = 7'h01;
  localparam logic [3:0]   CMD_FETCH    = 4'h1;
  localparam logic [3:0]   CMD_RD       = 4'h2;
  localparam logic [3:0]   CMD_WR       = 4'h4;
  // register map
  localparam int           REG_COUNT    = 5;
  localparam logic [2:0]   REG_LAST     = 3'h4;
  localparam logic [2:0]   ADDR_MODE    = 3'h1;
  localparam logic [2:0]   ADDR_STAT    = 3'h2;
  localparam logic [2:0]   ADDR_READ    = 3'h3;
  localparam logic [2:0]   ADDR_PIN     = 3'h4;
  localparam logic [7:0]   REG_RESET    = 8'h00;
  localparam logic [7:0]   REG_NONE     = 8'h00;
  localparam int           CM_BIT       = 3;
  localparam int           TURBO_BIT    = 4;
  localparam int           READY_BIT    = 7;
  localparam int           DCNT_BIT     = 6;
  localparam int           AUTO_BIT     = 0;
  localparam int           PIN2_DIR_BIT = 6;
  localparam int           PIN2_SEL_BIT = 3;
  localparam int           PIN2_DAT_BIT = 2;
  // result coding
  localparam logic [15:0]  CLIP_POS     = 16'h7fff;
  localparam logic [15:0]  CLIP_NEG     = 16'h8000;
  // timing: 32760 modulator periods at 256 kHz equals 65520 at 512 kHz
  localparam int           CLK_NS       = 50;
  localparam int           TIMEOUT_NS   = 127968750;
  localparam int           TIMEOUT_CYC  = TIMEOUT_NS / CLK_NS;

  typedef enum logic [1:0] {ST_SYNC, ST_CMD, ST_DATA} cmd_state_t;
  typedef enum logic [2:0] {
    RX_HUNT, RX_MEAS, RX_IDLE, RX_START, RX_BITS, RX_STOP
  } rx_state_t;
endpackage : adc_cmd_pkg

// file: src/adc_serial_port.sv
// half-duplex serial port with baud measurement on the sync byte
`timescale 1ns/10ps
`default_nettype none
module adc_serial_port
  import adc_cmd_pkg::*;
(
  // clock and reset
  input  wire  logic             clk_sys,
  input  wire  logic             reset,
  // receive side
  input  wire  logic             rx_in,
  input  wire  logic             resync,
  output var   logic             sync_done_q,
  output var   logic             byte_valid_q,
  output var   logic [7:0]       byte_data_q,
  // transmit side
  input  wire  logic             tx_load,
  input  wire  logic [7:0]       tx_data,
  output var   logic             tx_busy_q,
  output var   logic             tx_out_q
);
  rx_state_t         rx_st_q;
  logic              rx_prev_q;
  logic [CNT_W-1:0]  meas_q;
  logic [CNT_W-1:0]  period_q;
  logic [CNT_W-1:0]  rx_cnt_q;
  logic [2:0]        edges_q;
  logic [3:0]        rx_bit_q;
  logic [7:0]        rx_sh_q;
  logic [CNT_W-1:0]  tx_cnt_q;
  logic [3:0]        tx_bit_q;
  logic [8:0]        tx_sh_q;
  logic              fall;

  assign fall = rx_prev_q & ~rx_in;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_in;
    end
  end

  // the sync byte has falling edges eight bit periods apart end to end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_st_q      <= RX_HUNT;
      meas_q       <= '0;
      period_q     <= '0;
      rx_cnt_q     <= '0;
      edges_q      <= '0;
      rx_bit_q     <= '0;
      rx_sh_q      <= '0;
      sync_done_q  <= 1'b0;
      byte_valid_q <= 1'b0;
      byte_data_q  <= '0;
    end else begin
      sync_done_q  <= 1'b0;
      byte_valid_q <= 1'b0;
      if (resync) begin
        rx_st_q <= RX_HUNT;
      end else begin
        case (rx_st_q)
          RX_HUNT: if (fall) begin
            rx_st_q <= RX_MEAS;
            meas_q  <= CNT_W'(1);
            edges_q <= '0;
          end
          RX_MEAS: begin
            meas_q <= meas_q + CNT_W'(1);
            if (fall) begin
              edges_q <= edges_q + 3'h1;
              if (edges_q + 3'h1 == SYNC_EDGES) begin
                period_q    <= meas_q >> SYNC_SHIFT;
                rx_st_q     <= RX_IDLE;
                sync_done_q <= 1'b1;
              end
            end
          end
          RX_IDLE: if (fall) begin
            rx_st_q  <= RX_START;
            rx_cnt_q <= period_q >> 1;
          end
          RX_START: begin
            if (rx_cnt_q != '0) begin
              rx_cnt_q <= rx_cnt_q - CNT_W'(1);
            end else if (rx_in) begin
              rx_st_q <= RX_IDLE; // glitch, not a start bit
            end else begin
              // reload one short: the zero count is a cycle of its own
              rx_st_q  <= RX_BITS;
              rx_cnt_q <= period_q - CNT_W'(1);
              rx_bit_q <= '0;
            end
          end
          RX_BITS: begin
            if (rx_cnt_q != '0) begin
              rx_cnt_q <= rx_cnt_q - CNT_W'(1);
            end else begin
              rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
              rx_cnt_q <= period_q - CNT_W'(1);
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q + 4'h1 == DATA_BITS) begin
                rx_st_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_cnt_q != '0) begin
              rx_cnt_q <= rx_cnt_q - CNT_W'(1);
            end else begin
              // latch at mid stop bit, one clock of error at most
              rx_st_q <= RX_IDLE;
              if (rx_in) begin
                byte_valid_q <= 1'b1;
                byte_data_q  <= rx_sh_q;
              end
            end
          end
          default: rx_st_q <= RX_HUNT;
        endcase
      end
    end
  end

  // start bit, eight data bits lsb first, stop bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_out_q  <= 1'b1;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_sh_q   <= '1;
    end else if (!tx_busy_q) begin
      tx_out_q <= 1'b1;
      if (tx_load) begin
        tx_busy_q <= 1'b1;
        tx_out_q  <= 1'b0;
        tx_sh_q   <= {1'b1, tx_data};
        tx_cnt_q  <= period_q - CNT_W'(1);
        tx_bit_q  <= '0;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - CNT_W'(1);
    end else if (tx_bit_q == DATA_BITS + 4'h1) begin
      tx_busy_q <= 1'b0;
    end else begin
      tx_out_q <= tx_sh_q[0];
      tx_sh_q  <= {1'b1, tx_sh_q[8:1]};
      tx_cnt_q <= period_q - CNT_W'(1);
      tx_bit_q <= tx_bit_q + 4'h1;
    end
  end
endmodule : adc_serial_port
`default_nettype wire

// file: src/adc_cmd_readout.sv
// command decoder, conversion control and result readout
`timescale 1ns/10ps
`default_nettype none
module adc_cmd_readout
  import adc_cmd_pkg::*;
#(
  parameter int RAW_W       = 24,
  parameter int TIMEOUT_CNT = TIMEOUT_CYC
) (
  // clock and reset
  input  wire  logic                   clk_sys,
  input  wire  logic                   reset,
  // serial link
  input  wire  logic                   rx_in,
  output var   logic                   tx_out_q,
  // modulator and filter
  input  wire  logic                   conv_done,
  input  wire  logic signed [RAW_W-1:0] conv_raw,
  output var   logic                   conv_start_q,
  output var   logic                   filter_clear_q,
  output var   logic                   conv_active_q,
  output var   logic                   sleep_q,
  output var   logic                   turbo_q,
  // configuration bytes for the analog front end
  output var   logic [REG_COUNT*8-1:0] config_q,
  // general-purpose pin two
  output var   logic                   pin2_ready_output_q,
  output var   logic                   pin2_oe_n_q
);
  cmd_state_t        st_q;
  logic [31:0]       idle_q;
  logic [2:0]        addr_q;
  logic              resync_q;
  logic              sync_done;
  logic              byte_valid;
  logic [7:0]        byte_data;
  logic              tx_busy;
  logic              tx_load_q;
  logic [7:0]        tx_data_q;
  logic [7:0]        tx_buf_q [0:2];
  logic [1:0]        tx_left_q;
  logic [1:0]        tx_idx_q;
  logic [15:0]       result_q;
  logic [15:0]       clipped;
  logic [7:0]        counter_q;
  logic              result_ready_flag_q;
  logic              sleep_pend_q;
  logic              cmd_byte;
  logic              do_reset;
  logic              do_start;
  logic              do_sleep;
  logic              do_fetch;
  logic              do_read;
  logic              do_write;
  logic              auto_load;
  logic              in_single;

  adc_serial_port u_port (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .rx_in        (rx_in),
    .resync       (resync_q),
    .sync_done_q  (sync_done),
    .byte_valid_q (byte_valid),
    .byte_data_q  (byte_data),
    .tx_load      (tx_load_q),
    .tx_data      (tx_data_q),
    .tx_busy_q    (tx_busy),
    .tx_out_q     (tx_out_q)
  );

  // commands take effect only on a latched byte
  assign cmd_byte  = byte_valid && st_q == ST_CMD;
  assign do_reset  = cmd_byte && byte_data[7:1] == CMD_RESET;
  assign do_start  = cmd_byte && byte_data[7:1] == CMD_START;
  assign do_sleep  = cmd_byte && byte_data[7:1] == CMD_SLEEP;
  assign do_fetch  = cmd_byte && byte_data[7:4] == CMD_FETCH;
  assign do_read   = cmd_byte && byte_data[7:4] == CMD_RD;
  assign do_write  = byte_valid && st_q == ST_DATA && addr_q <= REG_LAST;
  assign in_single = ~config_q[8*ADDR_MODE + CM_BIT];
  assign auto_load = conv_done && config_q[8*ADDR_READ + AUTO_BIT] &&
                     tx_left_q == 2'h0;

  always_comb begin
    if (conv_raw > $signed({{(RAW_W-16){1'b0}}, CLIP_POS})) begin
      clipped = CLIP_POS;
    end else if (conv_raw < $signed({{(RAW_W-16){1'b1}}, CLIP_NEG})) begin
      clipped = CLIP_NEG;
    end else begin
      clipped = conv_raw[15:0];
    end
  end

  function automatic logic [7:0] reg_value(input logic [2:0] a,
                                           input logic [REG_COUNT*8-1:0] c,
                                           input logic rdy);
    logic [7:0] v;
    v = REG_NONE;
    if (a <= REG_LAST) begin
      v = c[8*a +: 8];
    end
    if (a == ADDR_STAT) begin
      v[READY_BIT] = rdy;
    end
    return v;
  endfunction : reg_value

  // command sequencing; every command is followed by a fresh sync byte
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q     <= ST_SYNC;
      idle_q   <= '0;
      addr_q   <= '0;
      resync_q <= 1'b0;
    end else begin
      resync_q <= 1'b0;
      idle_q   <= idle_q + 32'h1;
      case (st_q)
        ST_SYNC: begin
          idle_q <= '0;
          if (sync_done) begin
            st_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_valid && byte_data[7:4] == CMD_WR) begin
            st_q   <= ST_DATA;
            addr_q <= byte_data[3:1];
            idle_q <= '0;
          end else if (byte_valid) begin
            st_q     <= ST_SYNC;
            resync_q <= 1'b1;
          end else if (idle_q >= 32'(TIMEOUT_CNT)) begin
            st_q     <= ST_SYNC;
            resync_q <= 1'b1;
          end
        end
        ST_DATA: begin
          if (byte_valid || idle_q >= 32'(TIMEOUT_CNT)) begin
            st_q     <= ST_SYNC;
            resync_q <= 1'b1;
          end
        end
        default: st_q <= ST_SYNC;
      endcase
    end
  end

  // configuration registers; the ready bit is status, never stored
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      config_q <= {REG_COUNT{REG_RESET}};
    end else if (do_reset) begin
      config_q <= {REG_COUNT{REG_RESET}};
    end else if (do_write) begin
      config_q[8*addr_q +: 8] <= byte_data;
      if (addr_q == ADDR_STAT) begin
        config_q[8*ADDR_STAT + READY_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      turbo_q <= 1'b0;
    end else begin
      turbo_q <= config_q[8*ADDR_MODE + TURBO_BIT];
    end
  end

  // conversion control
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      conv_start_q   <= 1'b0;
      filter_clear_q <= 1'b0;
      conv_active_q  <= 1'b0;
      sleep_q        <= 1'b0;
      sleep_pend_q   <= 1'b0;
    end else begin
      conv_start_q   <= 1'b0;
      filter_clear_q <= 1'b0;
      if (do_reset) begin
        conv_active_q  <= 1'b0;
        sleep_q        <= 1'b0;
        sleep_pend_q   <= 1'b0;
        filter_clear_q <= 1'b1;
      end else if (do_start) begin
        conv_start_q   <= 1'b1;
        filter_clear_q <= conv_active_q;
        conv_active_q  <= 1'b1;
        sleep_q        <= 1'b0;
        sleep_pend_q   <= 1'b0;
      end else if (do_write && addr_q != ADDR_PIN && conv_active_q) begin
        conv_start_q   <= 1'b1;
        filter_clear_q <= 1'b1;
      end else if (do_sleep) begin
        // a running conversion is allowed to finish first
        if (conv_active_q) begin
          sleep_pend_q <= 1'b1;
        end else begin
          sleep_q <= 1'b1;
        end
      end else if (conv_done && conv_active_q) begin
        if (sleep_pend_q) begin
          conv_active_q <= 1'b0;
          sleep_q       <= 1'b1;
          sleep_pend_q  <= 1'b0;
        end else if (in_single) begin
          conv_active_q <= 1'b0;
        end
      end
    end
  end

  // newest result, its counter and the ready flag
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result_q            <= '0;
      counter_q           <= '0;
      result_ready_flag_q <= 1'b0;
    end else if (do_reset) begin
      result_q            <= '0;
      counter_q           <= '0;
      result_ready_flag_q <= 1'b0;
    end else begin
      if (conv_done) begin
        result_q  <= clipped;
        counter_q <= counter_q + 8'h1;
      end
      // a result arriving with the fetch stays unread: set wins unless auto_load is also high
      if (conv_done && !auto_load) begin
        result_ready_flag_q <= 1'b1;
      end else if (do_fetch || auto_load) begin
        result_ready_flag_q <= 1'b0;
      end
    end
  end

  // output bytes are captured at load, so later results cannot tear them
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_buf_q[0] <= '0;
      tx_buf_q[1] <= '0;
      tx_buf_q[2] <= '0;
      tx_left_q   <= '0;
      tx_idx_q    <= '0;
      tx_load_q   <= 1'b0;
      tx_data_q   <= '0;
    end else begin
      tx_load_q <= 1'b0;
      if (do_reset) begin
        tx_left_q <= '0;
      end else if (do_fetch || auto_load) begin
        tx_idx_q <= '0;
        if (config_q[8*ADDR_STAT + DCNT_BIT]) begin
          tx_buf_q[0] <= do_fetch ? counter_q : counter_q + 8'h1;
          tx_buf_q[1] <= do_fetch ? result_q[7:0] : clipped[7:0];
          tx_buf_q[2] <= do_fetch ? result_q[15:8] : clipped[15:8];
          tx_left_q   <= 2'h3;
        end else begin
          tx_buf_q[0] <= do_fetch ? result_q[7:0] : clipped[7:0];
          tx_buf_q[1] <= do_fetch ? result_q[15:8] : clipped[15:8];
          tx_left_q   <= 2'h2;
        end
      end else if (do_read) begin
        tx_buf_q[0] <= reg_value(byte_data[3:1], config_q,
                                 result_ready_flag_q);
        tx_idx_q    <= '0;
        tx_left_q   <= 2'h1;
      end else if (tx_left_q != 2'h0 && !tx_busy && !tx_load_q) begin
        tx_load_q <= 1'b1;
        tx_data_q <= tx_buf_q[tx_idx_q];
        tx_idx_q  <= tx_idx_q + 2'h1;
        tx_left_q <= tx_left_q - 2'h1;
      end
    end
  end

  // pin two: ready is active low and only shown when routed out
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin2_ready_output_q <= 1'b1;
      pin2_oe_n_q         <= 1'b1;
    end else begin
      pin2_oe_n_q <= ~config_q[8*ADDR_PIN + PIN2_DIR_BIT];
      if (config_q[8*ADDR_PIN + PIN2_DIR_BIT] &&
          config_q[8*ADDR_PIN + PIN2_SEL_BIT]) begin
        pin2_ready_output_q <= ~result_ready_flag_q;
      end else begin
        pin2_ready_output_q <= config_q[8*ADDR_PIN + PIN2_DAT_BIT];
      end
    end
  end
endmodule : adc_cmd_readout
`default_nettype wire

// file: bench/adc_cmd_readout_props.sv
// port-level checks for the command readout block
`timescale 1ns/10ps
`default_nettype none
module adc_cmd_readout_props
  import adc_cmd_pkg::*;
(
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   reset,
  // serial link
  input wire logic                   rx_in,
  input wire logic                   tx_out_q,
  // conversion control
  input wire logic                   conv_done,
  input wire logic                   conv_start_q,
  input wire logic                   filter_clear_q,
  input wire logic                   conv_active_q,
  input wire logic                   sleep_q,
  input wire logic                   turbo_q,
  // configuration and pin two
  input wire logic [REG_COUNT*8-1:0] config_q,
  input wire logic                   pin2_ready_output_q,
  input wire logic                   pin2_oe_n_q
);
  localparam int TURBO_IX = 8 + TURBO_BIT;
  localparam int DIR_IX   = 32 + PIN2_DIR_BIT;
  localparam int SEL_IX   = 32 + PIN2_SEL_BIT;
  localparam int AUTO_IX  = 24 + AUTO_BIT;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_reset_idle_state: assert property (
    $fell(reset) |-> tx_out_q && pin2_oe_n_q && config_q == '0)
    else $error("outputs not idle after reset");
  a_start_one_cycle: assert property (
    conv_start_q |=> !conv_start_q)
    else $error("start pulse longer than one cycle");
  a_clear_with_start: assert property (
    filter_clear_q |-> conv_start_q && $past(conv_active_q) && conv_active_q
      || !conv_start_q && !conv_active_q && config_q == '0)
    else $error("filter clear without restart of a running conversion");
  a_write_restarts_conv: assert property (
    $changed(config_q[31:0]) && conv_active_q |-> ##[0:1] filter_clear_q)
    else $error("config write while active did not restart");
  a_pin_write_quiet: assert property (
    $changed(config_q[39:32]) |->
      !conv_start_q && (!filter_clear_q || !conv_active_q))
    else $error("pin register write restarted conversion");
  a_pin_dir_follows: assert property (
    $stable(config_q) [*2] |-> pin2_oe_n_q == !config_q[DIR_IX])
    else $error("pin two enable disagrees with direction bit");
  a_turbo_follows_cfg: assert property (
    $stable(config_q) [*2] |-> turbo_q == config_q[TURBO_IX])
    else $error("turbo level disagrees with mode register");
  a_ready_on_pin: assert property (
    conv_done && config_q[DIR_IX] && config_q[SEL_IX] && !config_q[AUTO_IX]
    |-> ##[1:3] !pin2_ready_output_q)
    else $error("ready not shown on pin two after a result");
  a_sleep_when_idle: assert property (
    $rose(sleep_q) |-> !conv_active_q)
    else $error("sleep entered while converting");
  a_tx_half_duplex: assert property (
    $fell(tx_out_q) |-> rx_in)
    else $error("transmit started while host was sending");
endmodule : adc_cmd_readout_props

bind adc_cmd_readout adc_cmd_readout_props u_props (.*);
`default_nettype wire

// file: bench/adc_host_model.sv
// host side of the serial link: sends frames, collects replies
`timescale 1ns/10ps
`default_nettype none
module adc_host_model #(
  parameter int BIT_CYC = 16
) (
  // clock
  input  wire logic clk_sys,
  // serial lines
  input  wire logic tx_line,
  output var  logic rx_line
);
  initial rx_line = 1'b1;

  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
  endtask : send_byte

  // unknown result when no frame or no stop bit arrives in time
  task automatic recv_byte(output logic [7:0] d);
    logic [7:0] s;
    int         n;
    d = 'x;
    n = 0;
    while (tx_line !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (tx_line === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_sys);
        s[i] = tx_line;
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      if (tx_line === 1'b1) d = s;
    end
  endtask : recv_byte
endmodule : adc_host_model
`default_nettype wire

// file: bench/adc_uart_command_readout_tb_top.sv
// self-checking bench for the command readout block
`timescale 1ns/10ps
`default_nettype none
module adc_uart_command_readout_tb_top;
  import adc_cmd_pkg::*;
  localparam int RAW_W = 24;
  localparam int reset_recovery_delay = 64;
  logic                    clk_sys, reset, conv_done, rx_in, tx_out_q;
  logic signed [RAW_W-1:0] conv_raw;
  logic                    conv_start_q, filter_clear_q, conv_active_q;
  logic                    sleep_q, turbo_q, pin2_ready_output_q, pin2_oe_n_q;
  logic [REG_COUNT*8-1:0]  config_q, cfg;
  logic [15:0]             v;
  logic [7:0]              b;
  int                      miscompares = 0, n_checks = 0;
  int                      n_st = 0, n_cl = 0, n0;
  logic [7:0]  wv [8] = '{8'h5a, 8'h10, 8'h05, 8'he4, 8'h48, 8'hff, 8'hff,
                          8'hff};
  logic signed [RAW_W-1:0] raws [7] = '{24'sd5, 24'sd32767, 24'sd32768,
    -24'sd32768, -24'sd32769, -24'sd1, 24'sd0};
  logic [15:0] exps [7] = '{16'h0005, 16'h7fff, 16'h7fff, 16'h8000, 16'h8000,
                            16'hffff, 16'h0000};
  logic signed [RAW_W-1:0] seqr [3] = '{24'sd291, 24'sd1110, 24'sd1383};
  logic [7:0]  junk [5] = '{8'hff, 8'h0c, 8'h80, 8'h0a, 8'h30};

  adc_cmd_readout #(.RAW_W(RAW_W), .TIMEOUT_CNT(2000)) uut (.*);
  adc_host_model #(.BIT_CYC(16)) host (
    .clk_sys(clk_sys), .tx_line(tx_out_q), .rx_line(rx_in));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (conv_start_q === 1'b1) n_st++;
    if (filter_clear_q === 1'b1) n_cl++;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] c);
    host.send_byte(SYNC_BYTE);
    host.send_byte(c);
  endtask : cmd

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cmd({CMD_WR, a, 1'b0});
    host.send_byte(d);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    fork
      cmd({CMD_RD, a, 1'b0});
      host.recv_byte(d);
    join
  endtask : rd

  task automatic fetch(output logic [15:0] d);
    fork
      cmd({CMD_FETCH, 4'h0});
      begin
        host.recv_byte(d[7:0]);
        host.recv_byte(d[15:8]);
      end
    join
  endtask : fetch

  task automatic done(input logic signed [RAW_W-1:0] r);
    conv_done <= 1'b1;
    conv_raw  <= r;
    @(posedge clk_sys);
    conv_done <= 1'b0;
  endtask : done

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    reset     = 1'b1;
    conv_done = 1'b0;
    conv_raw  = '0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk({tx_out_q, pin2_ready_output_q, pin2_oe_n_q, sleep_q}, 4'he);
    chk(config_q, '0);
    for (int a = 0; a < 8; a++) wr(a[2:0], wv[a]);
    cfg = {wv[4], wv[3], wv[2], wv[1], wv[0]};
    chk(config_q, cfg);
    // abandoned command: the reads below only work after the timeout
    host.send_byte(SYNC_BYTE);
    repeat (2200) @(posedge clk_sys);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], b);
      chk(b, a < 5 ? wv[a] : REG_NONE);
    end
    chk({turbo_q, pin2_oe_n_q, pin2_ready_output_q}, 3'h5);
    foreach (raws[i]) begin
      n0 = n_st;
      cmd({CMD_START, 1'b0});
      chk(n_st - n0, 1);
      done(raws[i]);
      repeat (3) @(posedge clk_sys);
      chk(pin2_ready_output_q, 1'b0);
      rd(ADDR_STAT, b);
      chk(b, {1'b1, wv[2][6:0]});
      fetch(v);
      chk(v, exps[i]);
      chk(pin2_ready_output_q, 1'b1);
    end
    // continuous mode so results keep landing
    wr(ADDR_MODE, 8'h18);
    cmd({CMD_START, 1'b0});
    done(seqr[0]);
    for (int k = 1; k < 3; k++) begin
      fork
        fetch(v);
        begin
          // first lands in the fetch's own cycle, second mid-transmission
          repeat (k == 1 ? 314 : 400) @(posedge clk_sys);
          done(seqr[k]);
        end
      join
      chk(v, seqr[k-1][15:0]);
      chk(pin2_ready_output_q, 1'b0);
    end
    fetch(v);
    chk(v, 16'h0567);
    wr(ADDR_STAT, 8'h40);
    fork
      cmd({CMD_FETCH, 4'h0});
      begin
        host.recv_byte(b);
        host.recv_byte(v[7:0]);
        host.recv_byte(v[15:8]);
      end
    join
    chk(b, 8'h0a);
    chk(v, 16'h0567);
    n0 = n_cl;
    cmd({CMD_START, 1'b0});
    chk(n_cl - n0, 1);
    wr(ADDR_PIN, 8'h4c);
    chk(n_cl - n0, 1);
    wr(3'h0, 8'h33);
    chk(n_cl - n0, 2);
    cmd({CMD_SLEEP, 1'b0});
    chk(sleep_q, 1'b0);
    done(24'sd1);
    repeat (3) @(posedge clk_sys);
    chk({sleep_q, conv_active_q}, 2'h2);
    cfg = {8'h4c, wv[3], 8'h40, 8'h18, 8'h33};
    chk(config_q, cfg);
    n0 = n_st;
    foreach (junk[i]) cmd(junk[i]);
    chk(n_st - n0, 0);
    chk({config_q, sleep_q}, {cfg, 1'b1});
    wr(ADDR_READ, wv[3] | 8'h01);
    cmd({CMD_START, 1'b0});
    chk(sleep_q, 1'b0);
    fork
      begin
        host.recv_byte(b);
        host.recv_byte(v[7:0]);
        host.recv_byte(v[15:8]);
      end
      begin
        repeat (20) @(posedge clk_sys);
        done(-24'sd2);
      end
    join
    chk(b, 8'h0c);
    chk(v, 16'hfffe);
    cmd({CMD_RESET, 1'b0});
    repeat (reset_recovery_delay) @(posedge clk_sys);
    chk(config_q, '0);
    chk({turbo_q, conv_active_q, pin2_oe_n_q}, 3'h1);
    tally_and_finish;
  end
endmodule : adc_uart_command_readout_tb_top
`default_nettype wire
